// ===== hdl/rpas_pkg.sv
package rpas_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] RPAS_OFS_RESET_POWERDOWN_CONTROL = 8'h00;
   localparam logic [7:0] RPAS_OFS_ACTIVATION_STATUS = 8'h04;
   localparam logic [7:0] RPAS_OFS_ACTIVATION_CONTROL = 8'h08;
   localparam logic [7:0] RPAS_OFS_INTERRUPT_STATUS = 8'h0c;
   localparam logic [7:0] RPAS_OFS_INTERRUPT_MASK = 8'h10;
   localparam logic [7:0] RPAS_OFS_OVERLAY_ACCESS_SELECT = 8'h14;
   localparam logic [7:0] RPAS_OFS_DCHANNEL_ACCESS = 8'h18;
   localparam logic [7:0] RPAS_OFS_MAINT_CONTROL = 8'h1c;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int RPAS_B_SOFT_RESET = 3;
   localparam int RPAS_B_PD_ENABLE = 2;
   localparam int RPAS_B_ABS_PD = 1;
   localparam int RPAS_B_RET_NORMAL = 0;
   localparam int RPAS_B_LINK_UP = 3;
   localparam int RPAS_B_ERROR_IND = 2;
   localparam int RPAS_B_SF_SYNC = 1;
   localparam int RPAS_B_TRANSPARENT = 0;
   localparam int RPAS_B_ACT_REQ = 3;
   localparam int RPAS_B_DEACT_REQ = 2;
   localparam int RPAS_B_CUST_EN = 0;
   localparam int RPAS_B_DCH_SEL = 1;
   localparam int RPAS_B_CRC_CORRUPT = 8;
   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [3:0] RPAS_NIBBLE_RST = 4'h0;
   localparam logic [7:0] RPAS_LOOPBACK_RST = 8'h00;
   localparam logic [3:0] RPAS_DCH_CODE = 4'hf;
   localparam logic [1:0] RPAS_RESP_OKAY = 2'b00;
   localparam logic [1:0] RPAS_RESP_SLVERR = 2'b10;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int RPAS_CLK_HZ = 20000000;
   localparam int RPAS_LOSS_MS = 480;
   localparam int RPAS_LOSS_CYCLES = RPAS_LOSS_MS * (RPAS_CLK_HZ / 1000);
   localparam int RPAS_MIN_RESET_PERIODS = 6;
endpackage : rpas_pkg

// ===== hdl/rpas_top.sv
`timescale 1ns/10ps
// What this block does
// R1 - Hardware reset clears control; soft reset keeps it
// R2 - In absolute power-down only control register writable
// R3 - Soft reset bit holds transceiver in reset
// R4 - Controller holds reset six crystal periods
// R5 - Soft reset keeps control and overlay select
// R6 - Power-down enable while searching enters power-down
// R7 - Tone, activation request, enable clear exit power-down
// R8 - Enable zero forbids power-down; warm start kept
// R9 - Absolute power-down acts as soft reset
// R10 - Controller holds soft reset 1 ms after
// R11 - Hardware reset ends absolute power-down
// R12 - Absolute power-down clears coefficients, cold start
// R13 - Return-to-normal clears crc corrupt, loopbacks
// R14 - Resets clear status; edges raise change interrupt, except a falling error indication
// R15 - Reading status clears change interrupt
// R16 - Link up held until loss, deactivation, reset
// R17 - Timer expiry sets error indication
// R18 - Error cleared by request or tone, not read
// R19 - Superframe sync follows link; 480 ms deactivates
// R20 - No sync: no maintenance interrupts, ones data
// R21 - In-progress set on start, cleared on failure
// R22 - High error rate clears in-progress, ones data
// R23 - Pass data only when all gates open
// R24 - D-channel code 1111, cleared by D-channel access read
// R25 - Interrupt output when status and mask set
module rpas_top import rpas_pkg::*; #(
   parameter int LOSS_CYCLES = RPAS_LOSS_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic searching_i,
   input wire logic wakeup_tone_i,
   input wire logic act_start_i,
   input wire logic act_fail_i,
   input wire logic full_duplex_i,
   input wire logic sf_detect_i,
   input wire logic high_error_i,
   input wire logic timer_expire_i,
   input wire logic nt_mode_i,
   input wire logic verified_act_i,
   input wire logic verified_dea_m4_i,
   input wire logic dch_update_i,
   input wire logic [2:0] maint_irq_i,
   input wire logic [7:0] rx_data_i,
   output logic [7:0] rx_data_o,
   output logic xcvr_reset_o,
   output logic powerdown_o,
   output logic abs_powerdown_o,
   output logic clear_coeff_o,
   output logic irq_o,
   output logic [3:0] interrupt_status_o
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int NSYNC = 14;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [7:0] rxd1;
   logic [7:0] rxd2;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1 <= '0;
         sync2 <= '0;
         rxd1 <= 8'hff;
         rxd2 <= 8'hff;
      end else begin
         sync1 <= {searching_i, wakeup_tone_i, act_start_i, act_fail_i, full_duplex_i, sf_detect_i,
            high_error_i, timer_expire_i, nt_mode_i, verified_act_i, verified_dea_m4_i, maint_irq_i};
         sync2 <= sync1;
         rxd1 <= rx_data_i;
         rxd2 <= rxd1;
      end
   end
   logic s_search, s_tone, s_start, s_fail, s_fdx, s_sfdet, s_higherr, s_timer, s_nt, s_vact, s_vdea;
   logic [2:0] s_mirq;
   assign {s_search, s_tone, s_start, s_fail, s_fdx, s_sfdet, s_higherr, s_timer, s_nt, s_vact, s_vdea,
      s_mirq} = sync2;
   logic dch_s1, dch_s2, dch_s3;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dch_s1 <= 1'b0;
         dch_s2 <= 1'b0;
         dch_s3 <= 1'b0;
      end else begin
         dch_s1 <= dch_update_i;
         dch_s2 <= dch_s1;
         dch_s3 <= dch_s2;
      end
   end
   wire dch_event = dch_s2 & ~dch_s3;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [3:0] rpc;
   logic [3:0] act_stat;
   logic [3:0] act_ctrl;
   logic [3:0] int_stat;
   logic [3:0] int_mask;
   logic [3:0] ovl_sel;
   logic [7:0] loopback;
   logic crc_corrupt;
   logic dch_pending;
   logic pd_state;
   logic [31:0] sync_loss_cnt;

   wire soft_rst = rpc[RPAS_B_SOFT_RESET] | rpc[RPAS_B_ABS_PD]; // [R3] [R9]
   wire abs_pd = rpc[RPAS_B_ABS_PD];

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_ok;
   wire wr_go = aw_held & w_held & ~s_axi_bvalid_o;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RPAS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_ok ? RPAS_RESP_OKAY : RPAS_RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end
   assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
   assign s_axi_wready_o = ~w_held & ~s_axi_bvalid_o;
   wire wr_lane = w_strb[0];
   wire wr_rpc = wr_go & wr_lane & (aw_addr == RPAS_OFS_RESET_POWERDOWN_CONTROL);
   wire wr_other = wr_go & wr_lane & ~abs_pd; // [R2]
   wire wr_actc = wr_other & (aw_addr == RPAS_OFS_ACTIVATION_CONTROL);
   wire wr_mask = wr_other & (aw_addr == RPAS_OFS_INTERRUPT_MASK);
   wire wr_ovl = wr_other & (aw_addr == RPAS_OFS_OVERLAY_ACCESS_SELECT);
   wire wr_maint = wr_other & (aw_addr == RPAS_OFS_MAINT_CONTROL);
   always_comb begin
      if (aw_addr == RPAS_OFS_RESET_POWERDOWN_CONTROL || aw_addr == RPAS_OFS_ACTIVATION_STATUS ||
          aw_addr == RPAS_OFS_ACTIVATION_CONTROL || aw_addr == RPAS_OFS_INTERRUPT_STATUS ||
          aw_addr == RPAS_OFS_INTERRUPT_MASK || aw_addr == RPAS_OFS_OVERLAY_ACCESS_SELECT ||
          aw_addr == RPAS_OFS_DCHANNEL_ACCESS || aw_addr == RPAS_OFS_MAINT_CONTROL) begin
         wr_ok = 1'b1;
      end else begin
         wr_ok = 1'b0;
      end
   end

   logic [31:0] rd_val;
   logic rd_ok;
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      if (abs_pd) begin
         rd_val = 32'h0000_0000; // [R2]
      end else if (s_axi_araddr_i == RPAS_OFS_RESET_POWERDOWN_CONTROL) begin
         rd_val = {28'h0, rpc};
      end else if (s_axi_araddr_i == RPAS_OFS_ACTIVATION_STATUS) begin
         rd_val = {28'h0, dch_pending ? RPAS_DCH_CODE : act_stat}; // [R24]
      end else if (s_axi_araddr_i == RPAS_OFS_ACTIVATION_CONTROL) begin
         rd_val = {28'h0, act_ctrl};
      end else if (s_axi_araddr_i == RPAS_OFS_INTERRUPT_STATUS) begin
         rd_val = {28'h0, int_stat};
      end else if (s_axi_araddr_i == RPAS_OFS_INTERRUPT_MASK) begin
         rd_val = {28'h0, int_mask};
      end else if (s_axi_araddr_i == RPAS_OFS_OVERLAY_ACCESS_SELECT) begin
         rd_val = {28'h0, ovl_sel};
      end else if (s_axi_araddr_i == RPAS_OFS_DCHANNEL_ACCESS) begin
         rd_val = {31'h0, dch_pending};
      end else if (s_axi_araddr_i == RPAS_OFS_MAINT_CONTROL) begin
         rd_val = {23'h0, crc_corrupt, loopback};
      end else begin
         rd_ok = 1'b0;
      end
   end
   wire rd_go = s_axi_arvalid_i & s_axi_arready_o;
   wire rd_stat = rd_go & ~abs_pd & (s_axi_araddr_i == RPAS_OFS_ACTIVATION_STATUS);
   wire rd_dch = rd_go & ~abs_pd & (s_axi_araddr_i == RPAS_OFS_DCHANNEL_ACCESS);
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= RPAS_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_val;
         s_axi_rresp_o <= rd_ok ? RPAS_RESP_OKAY : RPAS_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end
   assign s_axi_arready_o = ~s_axi_rvalid_o;

   // ----------------------------------------
   // Reset and power-down control
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rpc <= RPAS_NIBBLE_RST; // [R1] [R11]
      end else if (wr_rpc) begin
         rpc <= {w_data[3:1], 1'b0}; // [R5]
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ovl_sel <= RPAS_NIBBLE_RST;
      end else if (wr_ovl) begin
         ovl_sel <= w_data[3:0]; // [R5]
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         loopback <= RPAS_LOOPBACK_RST;
         crc_corrupt <= 1'b0;
      end else if (wr_rpc && w_data[RPAS_B_RET_NORMAL]) begin
         loopback <= RPAS_LOOPBACK_RST; // [R13]
         crc_corrupt <= 1'b0;
      end else if (soft_rst) begin
         loopback <= RPAS_LOOPBACK_RST;
         crc_corrupt <= 1'b0;
      end else if (wr_maint) begin
         loopback <= w_data[7:0];
         crc_corrupt <= w_data[RPAS_B_CRC_CORRUPT];
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_ctrl <= RPAS_NIBBLE_RST;
      end else if (soft_rst) begin
         act_ctrl <= RPAS_NIBBLE_RST;
      end else if (wr_actc) begin
         act_ctrl <= w_data[3:0];
      end else if (s_start) begin
         act_ctrl[RPAS_B_ACT_REQ] <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_mask <= RPAS_NIBBLE_RST;
      end else if (soft_rst) begin
         int_mask <= RPAS_NIBBLE_RST;
      end else if (wr_mask) begin
         int_mask <= w_data[3:0];
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pd_state <= 1'b0;
      end else if (!rpc[RPAS_B_PD_ENABLE] || soft_rst || s_tone || act_ctrl[RPAS_B_ACT_REQ]) begin
         pd_state <= 1'b0; // [R7] [R8]
      end else if (s_search) begin
         pd_state <= 1'b1; // [R6]
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xcvr_reset_o <= 1'b0;
         abs_powerdown_o <= 1'b0;
         powerdown_o <= 1'b0;
         clear_coeff_o <= 1'b0;
      end else begin
         xcvr_reset_o <= soft_rst; // [R3] [R9]
         abs_powerdown_o <= abs_pd; // [R9]
         powerdown_o <= pd_state | abs_pd; // [R6]
         clear_coeff_o <= abs_pd; // [R12]
      end
   end

   // ----------------------------------------
   // Activation status
   // ----------------------------------------
   wire lu = act_stat[RPAS_B_LINK_UP];
   wire lost = sync_loss_cnt >= LOSS_CYCLES;
   wire deact = (s_nt & ~s_sfdet & (act_ctrl[RPAS_B_DEACT_REQ] | s_vdea)) |
      (~s_nt & act_ctrl[RPAS_B_DEACT_REQ]);
   logic [3:0] next_stat;
   always_comb begin
      next_stat = act_stat;
      if (s_fdx && s_sfdet && !lu) begin
         next_stat[RPAS_B_LINK_UP] = 1'b1; // [R16]
         next_stat[RPAS_B_SF_SYNC] = 1'b1; // [R19]
      end else if (lu) begin
         next_stat[RPAS_B_SF_SYNC] = s_sfdet; // [R19]
         next_stat[RPAS_B_TRANSPARENT] = ~s_higherr; // [R22]
      end
      if (lost || deact) begin
         next_stat[RPAS_B_LINK_UP] = 1'b0; // [R16] [R19]
         next_stat[RPAS_B_SF_SYNC] = 1'b0;
         next_stat[RPAS_B_TRANSPARENT] = 1'b0;
      end
      if (s_start) begin
         next_stat[RPAS_B_TRANSPARENT] = 1'b1; // [R21]
      end
      if (s_fail) begin
         next_stat[RPAS_B_TRANSPARENT] = 1'b0; // [R21]
         next_stat[RPAS_B_ERROR_IND] = 1'b1;
      end
      if (act_ctrl[RPAS_B_ACT_REQ] || s_tone) begin
         next_stat[RPAS_B_ERROR_IND] = 1'b0; // [R18]
      end
      if (s_timer || lost) begin
         next_stat[RPAS_B_ERROR_IND] = 1'b1; // [R17]
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_stat <= RPAS_NIBBLE_RST;
      end else if (soft_rst) begin
         act_stat <= RPAS_NIBBLE_RST; // [R14] [R16]
      end else begin
         act_stat <= next_stat;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_loss_cnt <= 32'h0000_0000;
      end else if (soft_rst || !lu || act_stat[RPAS_B_SF_SYNC]) begin
         sync_loss_cnt <= 32'h0000_0000;
      end else if (!lost) begin
         sync_loss_cnt <= sync_loss_cnt + 32'h0000_0001; // [R19]
      end
   end

   // ----------------------------------------
   // Interrupt status and D-channel overlay
   // ----------------------------------------
   wire stat_change = |(next_stat & ~act_stat) |
      |(act_stat & ~next_stat & 4'b1011); // [R14]
   wire stat_event = stat_change & ~soft_rst;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dch_pending <= 1'b0;
      end else if (soft_rst || !ovl_sel[RPAS_B_DCH_SEL]) begin
         dch_pending <= 1'b0;
      end else if (dch_event) begin
         dch_pending <= 1'b1; // [R24]
      end else if (rd_dch) begin
         dch_pending <= 1'b0; // [R24]
      end
   end
   logic act_irq;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_irq <= 1'b0;
      end else if (soft_rst) begin
         act_irq <= 1'b0;
      end else if (stat_event) begin
         act_irq <= 1'b1; // [R14]
      end else if (rd_stat) begin
         act_irq <= 1'b0; // [R15]
      end
   end
   logic [2:0] maint_stat;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         maint_stat <= 3'b000;
      end else if (soft_rst) begin
         maint_stat <= 3'b000;
      end else if (act_stat[RPAS_B_SF_SYNC]) begin
         maint_stat <= maint_stat | s_mirq; // [R20]
      end
   end
   assign int_stat = {act_irq | dch_pending, maint_stat};
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
         interrupt_status_o <= RPAS_NIBBLE_RST;
      end else begin
         irq_o <= |(int_stat & int_mask); // [R25]
         interrupt_status_o <= int_stat;
      end
   end

   // ----------------------------------------
   // Receive data gating
   // ----------------------------------------
   wire pass = (&{act_stat[RPAS_B_LINK_UP], act_stat[RPAS_B_SF_SYNC], act_stat[RPAS_B_TRANSPARENT]}) &
      (act_ctrl[RPAS_B_CUST_EN] | s_vact) & ~pd_state;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_data_o <= 8'hff;
      end else begin
         rx_data_o <= pass ? rxd2 : 8'hff; // [R23] [R20] [R22]
      end
   end
endmodule : rpas_top

// ===== verif/rpas_top_monitor.sv
`timescale 1ns/10ps
module rpas_top_monitor (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_rvalid_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic wakeup_tone_i,
   input wire logic sf_detect_i,
   input wire logic [7:0] rx_data_o,
   input wire logic xcvr_reset_o,
   input wire logic powerdown_o,
   input wire logic abs_powerdown_o,
   input wire logic clear_coeff_o,
   input wire logic irq_o,
   input wire logic [3:0] interrupt_status_o
);
   // ----------------------------------------
   // Port checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_aw_taken;
      s_axi_awvalid_i && s_axi_awready_o;
   endsequence
   sequence s_rd_in_abs;
      abs_powerdown_o && s_axi_rvalid_o;
   endsequence
   property p_wr_resp; s_aw_taken |-> ##[1:4] s_axi_bvalid_o; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
   property p_abs_read; s_rd_in_abs |-> s_axi_rdata_o == 32'h0; endproperty
   a_abs_read: assert property (p_abs_read) else $error("read data in absolute power-down");
   property p_abs_coeff; clear_coeff_o == abs_powerdown_o; endproperty
   a_abs_coeff: assert property (p_abs_coeff) else $error("coefficient clear mismatch");
   property p_abs_reset; abs_powerdown_o |-> xcvr_reset_o; endproperty
   a_abs_reset: assert property (p_abs_reset) else $error("absolute power-down without reset");
   property p_irq; irq_o |-> interrupt_status_o != 4'h0 || $past(interrupt_status_o) != 4'h0; endproperty
   a_irq: assert property (p_irq) else $error("interrupt without status");
   property p_tone; wakeup_tone_i [*5] |-> !powerdown_o; endproperty
   a_tone: assert property (p_tone) else $error("power-down kept during tone");
   property p_sync_ones; !sf_detect_i [*6] |-> rx_data_o == 8'hff; endproperty
   a_sync_ones: assert property (p_sync_ones) else $error("data passed without sync");
   property p_reset_ones; xcvr_reset_o [*3] |-> rx_data_o == 8'hff; endproperty
   a_reset_ones: assert property (p_reset_ones) else $error("data passed in reset");
endmodule : rpas_top_monitor

bind rpas_top rpas_top_monitor u_rpas_top_monitor (.*);

// ===== verif/rpas_mcu_model.sv
`timescale 1ns/10ps
module rpas_mcu_model (
   input wire logic clk_sys_i,
   output logic rst_n_i,
   output logic [7:0] s_axi_awaddr_i,
   output logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   output logic [31:0] s_axi_wdata_i,
   output logic [3:0] s_axi_wstrb_i,
   output logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   output logic s_axi_bready_i,
   output logic [7:0] s_axi_araddr_i,
   output logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   output logic s_axi_rready_i
);
   // ----------------------------------------
   // Controller bus cycles
   // ----------------------------------------
   logic hung = 1'b0;
   task automatic hw_reset;
      rst_n_i <= 1'b0;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
   endtask : hw_reset
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         n++;
      end while (!s_axi_bvalid_o && n < 100);
      r = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
      if (n >= 100) hung = 1'b1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         n++;
      end while (!s_axi_rvalid_o && n < 100);
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
      if (n >= 100) hung = 1'b1;
   endtask : rd
   initial begin
      {s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wdata_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
      {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
      s_axi_wstrb_i = 4'hf;
      hw_reset();
   end
endmodule : rpas_mcu_model

// ===== verif/reset_powerdown_activation_status_test.sv
`timescale 1ns/10ps
module reset_powerdown_activation_status_test import rpas_pkg::*;;
   // ----------------------------------------
   // Bench
   // ----------------------------------------
   localparam int LOSS = 50;
   localparam logic [7:0] CTL = RPAS_OFS_RESET_POWERDOWN_CONTROL;
   localparam logic [7:0] STA = RPAS_OFS_ACTIVATION_STATUS;
   localparam logic [7:0] ACT = RPAS_OFS_ACTIVATION_CONTROL;
   localparam logic [7:0] MSK = RPAS_OFS_INTERRUPT_MASK;
   localparam logic [7:0] OVL = RPAS_OFS_OVERLAY_ACCESS_SELECT;
   logic clk_sys_i = 1'b0, searching_i = 1'b0, wakeup_tone_i = 1'b0, act_start_i = 1'b0, act_fail_i = 1'b0;
   logic full_duplex_i = 1'b0, sf_detect_i = 1'b0, high_error_i = 1'b0, timer_expire_i = 1'b0, nt_mode_i = 1'b0;
   logic verified_act_i = 1'b0, verified_dea_m4_i = 1'b0, dch_update_i = 1'b0;
   logic [2:0] maint_irq_i = 3'h0;
   logic [7:0] rx_data_i = 8'h00;
   wire [7:0] s_axi_awaddr_i, s_axi_araddr_i, rx_data_o;
   wire [31:0] s_axi_wdata_i, s_axi_rdata_o;
   wire [3:0] s_axi_wstrb_i, interrupt_status_o;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
   wire s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
   wire xcvr_reset_o, powerdown_o, abs_powerdown_o, clear_coeff_o, irq_o;
   int n_fail = 0;
   int samples_checked = 0;
   always #25 clk_sys_i = ~clk_sys_i;
   rpas_top #(.LOSS_CYCLES(LOSS)) u_rpas_top (.*);
   rpas_mcu_model u_rpas_mcu_model (.*);
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   always @(posedge u_rpas_mcu_model.hung) begin
      n_fail++;
      close_out();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : cyc
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      u_rpas_mcu_model.wr(a, d, r);
      chk(r, RPAS_RESP_OKAY);
   endtask : w
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      u_rpas_mcu_model.rd(a, d, r);
      chk(r, RPAS_RESP_OKAY);
      chk(d, e);
   endtask : rc
   task automatic t_soft;
      logic [31:0] d;
      logic [1:0] r;
      rc(CTL, 32'h0);
      rc(STA, 32'h0);
      u_rpas_mcu_model.rd(8'h40, d, r);
      chk(r, RPAS_RESP_SLVERR);
      w(OVL, 32'h2);
      w(MSK, 32'h8);
      w(CTL, 32'h8);
      cyc(3);
      chk(xcvr_reset_o, 1'b1);
      rc(CTL, 32'h8);
      rc(OVL, 32'h2);
      rc(MSK, 32'h0);
      w(CTL, 32'h0);
      cyc(3);
      chk(xcvr_reset_o, 1'b0);
      w(RPAS_OFS_MAINT_CONTROL, 32'h1ff);
      w(CTL, 32'h1);
      rc(RPAS_OFS_MAINT_CONTROL, 32'h0);
      rc(CTL, 32'h0);
   endtask : t_soft
   task automatic t_pd;
      searching_i <= 1'b1;
      cyc(6);
      chk(powerdown_o, 1'b0);
      w(CTL, 32'h4);
      cyc(6);
      chk(powerdown_o, 1'b1);
      w(CTL, 32'h0);
      cyc(6);
      chk(powerdown_o, 1'b0);
      w(CTL, 32'h4);
      wakeup_tone_i <= 1'b1;
      cyc(6);
      chk(powerdown_o, 1'b0);
      wakeup_tone_i <= 1'b0;
      w(ACT, 32'h8);
      cyc(6);
      chk(powerdown_o, 1'b0);
      w(ACT, 32'h0);
      w(CTL, 32'h0);
      searching_i <= 1'b0;
   endtask : t_pd
   task automatic t_abs;
      w(CTL, 32'h2);
      cyc(3);
      chk(abs_powerdown_o, 1'b1);
      chk(clear_coeff_o, 1'b1);
      chk(xcvr_reset_o, 1'b1);
      w(OVL, 32'h0);
      rc(CTL, 32'h0);
      w(CTL, 32'h8);
      cyc(20);
      chk(abs_powerdown_o, 1'b0);
      rc(OVL, 32'h2);
      w(CTL, 32'h6);
      u_rpas_mcu_model.hw_reset();
      chk(abs_powerdown_o, 1'b0);
      rc(CTL, 32'h0);
   endtask : t_abs
   task automatic t_act;
      logic [31:0] d;
      logic [1:0] r;
      timer_expire_i <= 1'b1;
      cyc(1);
      timer_expire_i <= 1'b0;
      cyc(5);
      rc(STA, 32'h4);
      rc(STA, 32'h4);
      w(ACT, 32'h8);
      cyc(4);
      rc(STA, 32'h0);
      w(MSK, 32'h8);
      act_start_i <= 1'b1;
      cyc(1);
      act_start_i <= 1'b0;
      cyc(4);
      chk(interrupt_status_o, 4'h8);
      chk(irq_o, 1'b1);
      rc(STA, 32'h1);
      cyc(2);
      chk(interrupt_status_o, 4'h0);
      chk(irq_o, 1'b0);
      rx_data_i <= 8'h5a;
      full_duplex_i <= 1'b1;
      sf_detect_i <= 1'b1;
      cyc(5);
      rc(STA, 32'hb);
      chk(rx_data_o, 8'hff);
      w(ACT, 32'h1);
      cyc(3);
      chk(rx_data_o, 8'h5a);
      high_error_i <= 1'b1;
      cyc(5);
      chk(rx_data_o, 8'hff);
      high_error_i <= 1'b0;
      cyc(5);
      chk(rx_data_o, 8'h5a);
      sf_detect_i <= 1'b0;
      cyc(5);
      chk(rx_data_o, 8'hff);
      chk(interrupt_status_o[3], 1'b1);
      cyc(LOSS + 10);
      u_rpas_mcu_model.rd(STA, d, r);
      chk(d[3:1], 3'b010);
   endtask : t_act
   task automatic t_dch;
      logic [31:0] d;
      logic [1:0] r;
      w(OVL, 32'h2);
      dch_update_i <= 1'b1;
      cyc(5);
      rc(STA, 32'hf);
      u_rpas_mcu_model.rd(RPAS_OFS_DCHANNEL_ACCESS, d, r);
      chk(d, 32'h1);
      dch_update_i <= 1'b0;
      rc(STA, 32'h0);
   endtask : t_dch
   initial begin
      wait (rst_n_i === 1'b1);
      t_soft();
      t_pd();
      t_abs();
      t_act();
      act_start_i <= 1'b0;
      full_duplex_i <= 1'b0;
      u_rpas_mcu_model.hw_reset();
      rc(STA, 32'h0);
      t_dch();
      close_out();
   end
endmodule : reset_powerdown_activation_status_test
